//--- hw/jrx_pkg.sv
/*
 * Constants for the receive link control register bank: register addresses,
 * field positions, reset values and encodings.
 * Assumes a single-byte, MSB-first serial control port with 15-bit addresses.
 */
package jrx_pkg;
	// ****************************************
	// Serial frame layout
	// ****************************************
	localparam int JRX_ADDR_W = 15;
	localparam int JRX_INSTR_BITS = 16;
	localparam int JRX_FRAME_BITS = 24;

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [14:0] JRX_A_SERDES_STATUS = 15'h0281;
	localparam logic [14:0] JRX_A_REF_PREDIV = 15'h0289;
	localparam logic [14:0] JRX_A_TERM_CAL = 15'h02A7;
	localparam logic [14:0] JRX_A_GEN_CTRL = 15'h0300;
	localparam logic [14:0] JRX_A_SUBCLASS = 15'h0301;
	localparam logic [14:0] JRX_A_LATENCY = 15'h0302;
	localparam logic [14:0] JRX_A_RX_DELAY = 15'h0304;
	localparam logic [14:0] JRX_A_CHK_0 = 15'h040E;
	localparam logic [14:0] JRX_A_CHK_1 = 15'h041E;
	localparam logic [14:0] JRX_A_CHK_2 = 15'h0426;
	localparam logic [14:0] JRX_A_CFG_FIRST = 15'h0450;
	localparam logic [14:0] JRX_A_CFG_LAST = 15'h045C;
	localparam int JRX_CFG_N = 13;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int JRX_B_TERM_CAL = 0;
	localparam int JRX_B_CHK_METHOD = 6;
	localparam int JRX_B_LINK_EN = 0;
	localparam int JRX_B_VCO_CAL = 2;

	// ****************************************
	// Reset values and encodings
	// ****************************************
	localparam logic [2:0] JRX_SUBCLASS_RST = 3'h1;
	localparam logic [2:0] JRX_SUBCLASS_0 = 3'h0;
	localparam logic [1:0] JRX_PREDIV_RST = 2'h0;
	localparam logic [1:0] JRX_PREDIV_4 = 2'h0;
	localparam logic [1:0] JRX_PREDIV_2 = 2'h1;
	localparam logic [1:0] JRX_PREDIV_1 = 2'h2;
	localparam logic [2:0] JRX_FACTOR_4 = 3'h4;
	localparam logic [2:0] JRX_FACTOR_2 = 3'h2;
	localparam logic [2:0] JRX_FACTOR_1 = 3'h1;
	localparam logic [3:0] JRX_ALL_LANES = 4'hF;
endpackage : jrx_pkg

//--- hw/jrx_link_ctrl.sv
/*
 * Receive link control and status register bank with serial control port,
 * checksum engine, receive multiframe clock delay and latency measurement.
 * Assumes all inputs, including the serial port pins, are synchronous to
 * sys_clk and that frame and processing clock rates arrive as enable pulses.
 */
`timescale 1ns/100ps

// What this block does
// [RULE1] Pre-divide code 01 divides the SERDES PLL reference by two.
// [RULE2] Pre-divide code 10 passes the SERDES PLL reference undivided.
// [RULE3] Code 00 divides by four; software keeps the divided reference in 35-80 MHz.
// [RULE4] Rising edge of termination bit starts calibration; steady level does not.
// [RULE5] Checksum method 0 sums the individual link configuration fields.
// [RULE6] Checksum method 1 sums packed configuration registers 0x450-0x45C modulo 256.
// [RULE7] Computed checksum reads back at 0x40E, 0x41E and 0x426.
// [RULE8] Software enables the link only after PLL lock, PHY on and VCO calibration done.
// [RULE9] Status bit 2 shows whether a VCO calibration is running.
// [RULE10] Three-bit subclass field: 000 subclass 0, 001 subclass 1, resets to 1.
// [RULE11] Read-only five-bit latency from receive multiframe clock to last lane boundary.
// [RULE12] Receive multiframe clock lags the local one by the programmed five-bit delay.
// [RULE13] Reserved bits read zero and writing them changes nothing.
module jrx_link_ctrl (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic spi_csb_n,
	input wire logic spi_sclk,
	input wire logic spi_sdio_in,
	output logic spi_sdio_out,
	output logic spi_sdio_oe,
	input wire logic [5:0] serdes_pll_status,
	input wire logic frame_clk_en,
	input wire logic pclk_en,
	input wire logic local_lmfc,
	input wire logic [3:0] lane_lmfc_boundary,
	output logic [2:0] ref_predivide_factor,
	output logic termination_cal_trigger,
	output logic link_enable,
	output logic [2:0] local_subclass_select,
	output logic rx_lmfc
);
	// ****************************************
	// Storage
	// ****************************************
	logic sclk_d;
	logic [4:0] bit_cnt;
	logic [15:0] instr;
	logic [7:0] wr_shift;
	logic [7:0] rd_shift;
	logic wr_commit;
	logic [14:0] wr_addr;
	logic [7:0] wr_data;
	logic [1:0] ref_clock_predivide_select;
	logic term_cal_bit;
	logic term_cal_bit_d;
	logic checksum_method;
	logic link_en_bit;
	logic [2:0] subclass_field;
	logic [4:0] multiframe_rx_offset;
	logic [4:0] measured_arrival_skew;
	logic [7:0] cfg_mem [0:12];
	logic [7:0] computed_checksum_regs;
	logic [7:0] next_checksum;
	logic [4:0] delay_cnt;
	logic delay_busy;
	logic [4:0] skew_cnt;
	logic [3:0] lanes_seen;
	logic [3:0] next_seen;
	logic delay_tick;
	logic sclk_rise;
	logic sclk_fall;

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic cfg_hit(input logic [14:0] a);
		cfg_hit = (a >= jrx_pkg::JRX_A_CFG_FIRST) && (a <= jrx_pkg::JRX_A_CFG_LAST);
	endfunction : cfg_hit

	function automatic logic [3:0] cfg_idx(input logic [14:0] a);
		logic [14:0] d;
		d = a - jrx_pkg::JRX_A_CFG_FIRST;
		cfg_idx = d[3:0];
	endfunction : cfg_idx

	function automatic logic [7:0] read_mux(input logic [14:0] a);
		read_mux = 8'h00; // RULE13
		case (a)
			jrx_pkg::JRX_A_SERDES_STATUS: read_mux = {2'b00, serdes_pll_status}; // RULE9
			jrx_pkg::JRX_A_REF_PREDIV: read_mux = {6'h00, ref_clock_predivide_select};
			jrx_pkg::JRX_A_TERM_CAL: read_mux = {7'h00, term_cal_bit};
			jrx_pkg::JRX_A_GEN_CTRL: read_mux = {1'b0, checksum_method, 5'h00, link_en_bit};
			jrx_pkg::JRX_A_SUBCLASS: read_mux = {5'h00, subclass_field};
			jrx_pkg::JRX_A_LATENCY: read_mux = {3'h0, measured_arrival_skew}; // RULE11
			jrx_pkg::JRX_A_RX_DELAY: read_mux = {3'h0, multiframe_rx_offset};
			jrx_pkg::JRX_A_CHK_0,
			jrx_pkg::JRX_A_CHK_1,
			jrx_pkg::JRX_A_CHK_2: read_mux = computed_checksum_regs; // RULE7
			default: begin
				if (cfg_hit(a)) begin
					read_mux = cfg_mem[cfg_idx(a)];
				end
			end
		endcase
	endfunction : read_mux

	// Sum of the separately packed link fields, each field counted on its own
	function automatic logic [7:0] field_sum(input logic [103:0] c);
		logic [7:0] s;
		s = c[7:0];
		s = s + {4'h0, c[11:8]};
		s = s + {3'h0, c[20:16]};
		s = s + {7'h00, c[31]} + {3'h0, c[28:24]};
		s = s + c[39:32];
		s = s + {3'h0, c[44:40]};
		s = s + c[55:48];
		s = s + {6'h00, c[63:62]} + {3'h0, c[60:56]};
		s = s + {5'h00, c[71:69]} + {3'h0, c[68:64]};
		s = s + {5'h00, c[79:77]} + {3'h0, c[76:72]};
		s = s + {7'h00, c[87]} + {3'h0, c[84:80]};
		field_sum = s;
	endfunction : field_sum

	assign sclk_rise = spi_sclk & ~sclk_d & ~spi_csb_n;
	assign sclk_fall = ~spi_sclk & sclk_d & ~spi_csb_n;

	// ****************************************
	// Serial control port
	// ****************************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sclk_d <= 1'b0;
		end else begin
			sclk_d <= spi_sclk;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bit_cnt <= 5'h00;
			instr <= 16'h0000;
			wr_shift <= 8'h00;
			wr_commit <= 1'b0;
			wr_addr <= 15'h0000;
			wr_data <= 8'h00;
		end else begin
			wr_commit <= 1'b0;
			if (spi_csb_n) begin
				bit_cnt <= 5'h00;
			end else if (sclk_rise && bit_cnt < 5'(jrx_pkg::JRX_FRAME_BITS)) begin
				bit_cnt <= bit_cnt + 5'h01;
				if (bit_cnt < 5'(jrx_pkg::JRX_INSTR_BITS)) begin
					instr <= {instr[14:0], spi_sdio_in};
				end else begin
					wr_shift <= {wr_shift[6:0], spi_sdio_in};
				end
				if (bit_cnt == 5'(jrx_pkg::JRX_FRAME_BITS - 1) && !instr[15]) begin
					wr_commit <= 1'b1;
					wr_addr <= instr[14:0];
					wr_data <= {wr_shift[6:0], spi_sdio_in};
				end
			end
		end
	end

	// Read data is launched on falling edges once the instruction is complete
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_shift <= 8'h00;
			spi_sdio_out <= 1'b0;
			spi_sdio_oe <= 1'b0;
		end else if (spi_csb_n) begin
			spi_sdio_oe <= 1'b0;
			spi_sdio_out <= 1'b0;
		end else if (sclk_fall && instr[15]) begin
			if (bit_cnt == 5'(jrx_pkg::JRX_INSTR_BITS)) begin
				spi_sdio_oe <= 1'b1;
				{spi_sdio_out, rd_shift} <= {read_mux(instr[14:0]), 1'b0};
			end else if (bit_cnt > 5'(jrx_pkg::JRX_INSTR_BITS)
					&& bit_cnt < 5'(jrx_pkg::JRX_FRAME_BITS)) begin
				spi_sdio_out <= rd_shift[7];
				rd_shift <= {rd_shift[6:0], 1'b0};
			end else begin
				spi_sdio_oe <= 1'b0;
			end
		end
	end

	// ****************************************
	// Writable registers
	// ****************************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ref_clock_predivide_select <= jrx_pkg::JRX_PREDIV_RST;
			term_cal_bit <= 1'b0;
			checksum_method <= 1'b0;
			link_en_bit <= 1'b0;
			subclass_field <= jrx_pkg::JRX_SUBCLASS_RST; // RULE10
			multiframe_rx_offset <= 5'h00;
		end else if (wr_commit) begin
			case (wr_addr)
				jrx_pkg::JRX_A_REF_PREDIV: ref_clock_predivide_select <= wr_data[1:0];
				jrx_pkg::JRX_A_TERM_CAL: term_cal_bit <= wr_data[jrx_pkg::JRX_B_TERM_CAL];
				jrx_pkg::JRX_A_GEN_CTRL: begin
					checksum_method <= wr_data[jrx_pkg::JRX_B_CHK_METHOD];
					link_en_bit <= wr_data[jrx_pkg::JRX_B_LINK_EN]; // RULE8
				end
				jrx_pkg::JRX_A_SUBCLASS: subclass_field <= wr_data[2:0]; // RULE10
				jrx_pkg::JRX_A_RX_DELAY: multiframe_rx_offset <= wr_data[4:0];
				default: begin
				end
			endcase
		end
	end

	generate
		for (genvar i = 0; i < jrx_pkg::JRX_CFG_N; i++) begin : g_cfg
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					cfg_mem[i] <= 8'h00;
				end else if (wr_commit && cfg_hit(wr_addr) && cfg_idx(wr_addr) == 4'(i)) begin
					cfg_mem[i] <= wr_data;
				end
			end
		end
	endgenerate

	// ****************************************
	// Control outputs
	// ****************************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ref_predivide_factor <= jrx_pkg::JRX_FACTOR_4;
		end else begin
			case (ref_clock_predivide_select)
				jrx_pkg::JRX_PREDIV_2: ref_predivide_factor <= jrx_pkg::JRX_FACTOR_2; // RULE1
				jrx_pkg::JRX_PREDIV_1: ref_predivide_factor <= jrx_pkg::JRX_FACTOR_1; // RULE2
				jrx_pkg::JRX_PREDIV_4: ref_predivide_factor <= jrx_pkg::JRX_FACTOR_4; // RULE3
				default: ref_predivide_factor <= jrx_pkg::JRX_FACTOR_4;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			term_cal_bit_d <= 1'b0;
			termination_cal_trigger <= 1'b0;
			link_enable <= 1'b0;
			local_subclass_select <= jrx_pkg::JRX_SUBCLASS_RST;
		end else begin
			term_cal_bit_d <= term_cal_bit;
			termination_cal_trigger <= term_cal_bit & ~term_cal_bit_d; // RULE4
			link_enable <= link_en_bit;
			local_subclass_select <= subclass_field;
		end
	end

	// ****************************************
	// Link parameter checksum
	// ****************************************
	always_comb begin
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < jrx_pkg::JRX_CFG_N; i++) begin
			s = s + cfg_mem[i];
		end
		if (checksum_method) begin
			next_checksum = s; // RULE6
		end else begin
			next_checksum = field_sum({cfg_mem[12], cfg_mem[11], cfg_mem[10], cfg_mem[9],
				cfg_mem[8], cfg_mem[7], cfg_mem[6], cfg_mem[5], cfg_mem[4], cfg_mem[3],
				cfg_mem[2], cfg_mem[1], cfg_mem[0]}); // RULE5
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			computed_checksum_regs <= 8'h00;
		end else begin
			computed_checksum_regs <= next_checksum; // RULE7
		end
	end

	// ****************************************
	// Receive multiframe clock delay
	// ****************************************
	assign delay_tick = (subclass_field == jrx_pkg::JRX_SUBCLASS_0) ? pclk_en : frame_clk_en;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			delay_cnt <= 5'h00;
			delay_busy <= 1'b0;
			rx_lmfc <= 1'b0;
		end else begin
			rx_lmfc <= 1'b0;
			if (local_lmfc) begin
				if (multiframe_rx_offset == 5'h00) begin
					rx_lmfc <= 1'b1; // RULE12
					delay_busy <= 1'b0;
				end else begin
					delay_cnt <= multiframe_rx_offset;
					delay_busy <= 1'b1;
				end
			end else if (delay_busy && delay_tick) begin
				delay_cnt <= delay_cnt - 5'h01;
				if (delay_cnt == 5'h01) begin
					rx_lmfc <= 1'b1; // RULE12
					delay_busy <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Latency measurement
	// ****************************************
	assign next_seen = lanes_seen | lane_lmfc_boundary;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			skew_cnt <= 5'h00;
			lanes_seen <= 4'h0;
			measured_arrival_skew <= 5'h00;
		end else if (!link_en_bit) begin
			skew_cnt <= 5'h00;
			lanes_seen <= 4'h0;
		end else if (rx_lmfc) begin
			skew_cnt <= 5'h00;
			lanes_seen <= 4'h0;
		end else if (lanes_seen != jrx_pkg::JRX_ALL_LANES) begin
			lanes_seen <= next_seen;
			if (next_seen == jrx_pkg::JRX_ALL_LANES) begin
				measured_arrival_skew <= skew_cnt; // RULE11
			end else if (pclk_en && skew_cnt != 5'h1F) begin
				skew_cnt <= skew_cnt + 5'h01;
			end
		end
	end
endmodule : jrx_link_ctrl

//--- bench/jrx_link_ctrl_properties.sv
/*
 * Port checker for the receive link control register bank.
 * Assumes bind to jrx_link_ctrl; all signals on sys_clk.
 */
`timescale 1ns/100ps
module jrx_link_ctrl_chk (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic spi_csb_n,
	input wire logic spi_sdio_oe,
	input wire logic [2:0] ref_predivide_factor,
	input wire logic termination_cal_trigger,
	input wire logic link_enable,
	input wire logic [2:0] local_subclass_select,
	input wire logic rx_lmfc
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence port_idle;
		spi_csb_n [*5];
	endsequence
	a_cal_single: assert property (
		termination_cal_trigger |=> !termination_cal_trigger) else $error("cal pulse too long");
	a_cal_idle: assert property (
		port_idle |-> !termination_cal_trigger) else $error("cal without write");
	a_factor_legal: assert property (
		ref_predivide_factor inside {3'h4, 3'h2, 3'h1}) else $error("bad divide factor");
	a_cfg_stable: assert property (
		port_idle |-> $stable(local_subclass_select) && $stable(link_enable)
		&& $stable(ref_predivide_factor)) else $error("control changed while idle");
	a_reset_values: assert property (
		$rose(rstn) |-> local_subclass_select == 3'h1 && ref_predivide_factor == 3'h4
		&& !link_enable) else $error("bad reset value");
	a_rx_single: assert property (
		rx_lmfc |=> !rx_lmfc) else $error("rx multiframe pulse too long");
	a_oe_idle: assert property (
		spi_csb_n [*2] |-> !spi_sdio_oe) else $error("drive while deselected");
	a_oe_frame: assert property (
		$rose(spi_sdio_oe) |-> !spi_csb_n) else $error("drive outside frame");
endmodule : jrx_link_ctrl_chk

bind jrx_link_ctrl jrx_link_ctrl_chk chk_u (.sys_clk(sys_clk), .rstn(rstn),
	.spi_csb_n(spi_csb_n), .spi_sdio_oe(spi_sdio_oe), .ref_predivide_factor(ref_predivide_factor),
	.termination_cal_trigger(termination_cal_trigger), .link_enable(link_enable),
	.local_subclass_select(local_subclass_select), .rx_lmfc(rx_lmfc));

//--- bench/jrx_tx_model.sv
/*
 * Transmitter model: lane multiframe boundaries arrive with per-lane skew.
 * Assumes local_lmfc is a one-cycle pulse on sys_clk.
 */
`timescale 1ns/100ps
module jrx_tx_model #(
	parameter int SKEW [4] = '{3, 7, 2, 5}
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic local_lmfc,
	output logic [3:0] lane_lmfc_boundary
);
	logic [31:0] hist;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hist <= 32'h0000_0000;
		end else begin
			hist <= {hist[30:0], local_lmfc};
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lane_lmfc_boundary[i] = hist[SKEW[i]];
		end
	end
endmodule : jrx_tx_model

//--- bench/jrx_link_ctrl_test.sv
/*
 * Bench for jrx_link_ctrl: serial access, divider, calibration, checksum, delay.
 * Assumes jrx_pkg, the checker and the transmitter model are compiled first.
 */
`timescale 1ns/100ps
module jrx_link_ctrl_test;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic csb_n = 1'b1;
	logic sclk = 1'b0;
	logic sdi = 1'b0;
	logic fce = 1'b0;
	logic pce = 1'b0;
	logic lmfc = 1'b0;
	logic [5:0] pll = 6'h00;
	logic sdo, oe, rxl, cal, len;
	logic [3:0] lanes;
	logic [2:0] fac, sc;
	logic [7:0] rd;
	logic [7:0] cfg [13];
	int n_errors = 0;
	int n_compared = 0;
	int n_cal = 0;
	int tk = 0;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		#1;
		pce = (tk % 2 == 0);
		fce = (tk % 3 == 0);
		tk++;
		if (cal === 1'b1) n_cal++;
	end
	jrx_link_ctrl dut_u (.sys_clk(sys_clk), .rstn(rstn), .spi_csb_n(csb_n), .spi_sclk(sclk),
		.spi_sdio_in(sdi), .spi_sdio_out(sdo), .spi_sdio_oe(oe), .serdes_pll_status(pll),
		.frame_clk_en(fce), .pclk_en(pce), .local_lmfc(lmfc), .lane_lmfc_boundary(lanes),
		.ref_predivide_factor(fac), .termination_cal_trigger(cal), .link_enable(len),
		.local_subclass_select(sc), .rx_lmfc(rxl));
	jrx_tx_model tx_u (.sys_clk(sys_clk), .rstn(rstn), .local_lmfc(lmfc),
		.lane_lmfc_boundary(lanes));
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] d);
		logic [23:0] f;
		f = {rw, a, d};
		csb_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi = f[i];
			cyc(2);
			if (i < 8) rd[i] = sdo;
			sclk = 1'b1;
			cyc(2);
			sclk = 1'b0;
		end
		cyc(2);
		csb_n = 1'b1;
		cyc(6);
	endtask : xfer
	task automatic rchk(input logic [14:0] a, input logic [7:0] e);
		xfer(1'b1, a, 8'h00);
		check(rd, e);
	endtask : rchk
	function automatic logic [7:0] fsum(input logic m);
		logic [7:0] s;
		s = 8'h00;
		if (m) begin
			for (int i = 0; i < 13; i++) s += cfg[i];
		end else begin
			s = cfg[0] + cfg[1][3:0] + cfg[2][4:0] + cfg[3][7] + cfg[3][4:0] + cfg[4]
				+ cfg[5][4:0] + cfg[6] + cfg[7][7:6] + cfg[7][4:0] + cfg[8][7:5]
				+ cfg[8][4:0] + cfg[9][7:5] + cfg[9][4:0] + cfg[10][7] + cfg[10][4:0];
		end
		return s;
	endfunction : fsum
	task automatic lat(input logic [2:0] s, input logic [4:0] o);
		logic [7:0] n;
		xfer(1'b0, jrx_pkg::JRX_A_SUBCLASS, {5'h1f, s});
		xfer(1'b0, jrx_pkg::JRX_A_RX_DELAY, {3'h7, o});
		check({5'h00, sc}, {5'h00, s});
		n = 8'h00;
		lmfc = 1'b1;
		cyc(1);
		lmfc = 1'b0;
		// Ticks are counted at the edge, where they hold the value the design samples
		for (int i = 0; i < 200 && rxl !== 1'b1; i++) begin
			@(posedge sys_clk);
			n += (s == 3'h0) ? pce : fce;
			#1;
		end
		if (rxl !== 1'b1) begin
			n_errors++;
			give_verdict();
		end
		check(n, {3'h0, o});
		cyc(40);
	endtask : lat
	initial begin
		void'($urandom(32'h7fa2));
		cyc(5);
		rstn = 1'b1;
		cyc(1);
		check({5'h00, sc}, 8'h01);
		rchk(jrx_pkg::JRX_A_SUBCLASS, 8'h01);
		rchk(jrx_pkg::JRX_A_GEN_CTRL, 8'h00);
		rchk(15'h7ff0, 8'h00);
		$display("done reset");
		for (int c = 0; c < 4; c++) begin
			xfer(1'b0, jrx_pkg::JRX_A_REF_PREDIV, {6'h3f, c[1:0]});
			check({5'h00, fac}, (c % 3 == 0) ? 8'h04 : (c == 1) ? 8'h02 : 8'h01);
			rchk(jrx_pkg::JRX_A_REF_PREDIV, {6'h00, c[1:0]});
		end
		$display("done predivide");
		xfer(1'b0, jrx_pkg::JRX_A_TERM_CAL, 8'hff);
		xfer(1'b0, jrx_pkg::JRX_A_TERM_CAL, 8'h01);
		rchk(jrx_pkg::JRX_A_TERM_CAL, 8'h01);
		check(n_cal[7:0], 8'h01);
		xfer(1'b0, jrx_pkg::JRX_A_TERM_CAL, 8'h00);
		xfer(1'b0, jrx_pkg::JRX_A_TERM_CAL, 8'h01);
		check(n_cal[7:0], 8'h02);
		$display("done calibration");
		for (int k = 0; k < 2; k++) begin
			pll = 6'($urandom);
			pll[2] = k[0];
			rchk(jrx_pkg::JRX_A_SERDES_STATUS, {2'b00, pll});
		end
		// Link is only enabled once the VCO calibration reads idle
		pll[2] = 1'b0;
		rchk(jrx_pkg::JRX_A_SERDES_STATUS, {2'b00, pll});
		for (int i = 0; i < 13; i++) begin
			cfg[i] = 8'($urandom);
			xfer(1'b0, jrx_pkg::JRX_A_CFG_FIRST + 15'(i), cfg[i]);
		end
		for (int m = 0; m < 2; m++) begin
			xfer(1'b0, jrx_pkg::JRX_A_GEN_CTRL, {1'b1, m[0], 6'h3f});
			rchk(jrx_pkg::JRX_A_GEN_CTRL, {1'b0, m[0], 6'h01});
			check({7'h00, len}, 8'h01);
			rchk(jrx_pkg::JRX_A_CHK_0, fsum(m[0]));
			rchk(jrx_pkg::JRX_A_CHK_1, fsum(m[0]));
			rchk(jrx_pkg::JRX_A_CHK_2, fsum(m[0]));
		end
		$display("done checksum");
		lat(3'h1, 5'h00);
		// Last lane lags the delayed clock by six counted cycles: three processing ticks
		xfer(1'b1, jrx_pkg::JRX_A_LATENCY, 8'h00);
		check(rd, 8'h03);
		lat(3'h0, 5'h1f);
		lat(3'h1, 5'($urandom));
		lat(3'h0, 5'($urandom));
		xfer(1'b1, jrx_pkg::JRX_A_LATENCY, 8'h00);
		check(rd & 8'he0, 8'h00);
		$display("done delay");
		give_verdict();
	end
endmodule : jrx_link_ctrl_test
